/* File: rx_fabric_word_packer.v */
// Receive fabric word packer: places lane data and status into a 32-bit word
`timescale 1ns/1ps
`include "rx_packer_defs.vh"

module rx_fabric_word_packer #(
    parameter CNT_W = 16
) (
    // Clock and reset
    input  wire          mclk,
    input  wire          rstn,
    // Lane 0 from the channel
    input  wire [9:0]    l0_code,
    input  wire          l0_ctrl,
    input  wire          l0_err,
    input  wire          l0_sync,
    input  wire          l0_disperr,
    input  wire          l0_patdet,
    input  wire          l0_rm_del,
    input  wire          l0_rm_ins,
    input  wire [1:0]    l0_pipe_st,
    input  wire          l0_rdisp,
    // Lane 1 from the channel
    input  wire [9:0]    l1_code,
    input  wire          l1_ctrl,
    input  wire          l1_err,
    input  wire          l1_sync,
    input  wire          l1_disperr,
    input  wire          l1_patdet,
    input  wire          l1_rm_del,
    input  wire          l1_rm_ins,
    input  wire [1:0]    l1_pipe_st,
    input  wire          l1_rdisp,
    // Word strobe from the channel
    input  wire          in_valid,
    // Register port
    input  wire [4:0]    reg_addr,
    input  wire [31:0]   reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output wire [31:0]   reg_rdata,
    // Fabric side
    output wire [31:0]   rx_word,
    output wire          rx_word_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    reg  [3:0]           ctrl_q;
    reg  [31:0]          word_q;
    reg  [31:0]          word_d;
    reg                  valid_q;
    reg  [31:0]          rdata_q;
    reg  [31:0]          rdata_d;
    reg                  sync0_q;
    reg                  sync1_q;

    wire                 enable;
    wire [1:0]           wmode;
    wire                 pipe;
    wire                 dbl;
    wire                 raw;
    wire [`LANE_W-1:0]   field0;
    wire [`LANE_W-1:0]   field1;
    wire [1:0]           del_inc;
    wire [1:0]           ins_inc;
    wire [CNT_W-1:0]     del_cnt;
    wire [CNT_W-1:0]     ins_cnt;
    wire                 del_clr;
    wire                 ins_clr;

    // Lane signals gathered so both lanes share one packer description
    wire [9:0]           code_v    [0:1];
    wire [1:0]           pst_v     [0:1];
    wire [1:0]           ctrl_v;
    wire [1:0]           err_v;
    wire [1:0]           sync_v;
    wire [1:0]           disp_v;
    wire [1:0]           pat_v;
    wire [1:0]           del_v;
    wire [1:0]           ins_v;
    wire [1:0]           rd_v;
    wire [`LANE_W-1:0]   field_v   [0:1];

    ////////////////////////////////////////////////////////////////////////
    // Functions
    // Mode decoding is shared by the lane packers, the word mux and the counters

    // True when the width mode carries two lanes in one word
    function is_double;
        input [1:0] m;
        begin
            is_double = (m == `WMODE_16) || (m == `WMODE_20);
        end
    endfunction

    // True when the width mode passes undecoded code groups
    function is_raw;
        input [1:0] m;
        begin
            is_raw = (m == `WMODE_10) || (m == `WMODE_20);
        end
    endfunction

    // Address decode used by the control write and the counter clears; the read path decodes with a case
    function hit;
        input [4:0] a;
        input [4:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control decode

    // Mode bits are live: a change takes effect on the next word
    assign enable = ctrl_q[`CTRL_EN];
    assign wmode  = ctrl_q[`CTRL_WMODE_HI:`CTRL_WMODE_LO];
    assign pipe   = ctrl_q[`CTRL_PIPE];
    assign dbl    = is_double(wmode);
    assign raw    = is_raw(wmode);

    ////////////////////////////////////////////////////////////////////////
    // Lane packing

    assign code_v[0] = l0_code;
    assign code_v[1] = l1_code;
    assign pst_v[0]  = l0_pipe_st;
    assign pst_v[1]  = l1_pipe_st;
    assign ctrl_v    = {l1_ctrl, l0_ctrl};
    assign err_v     = {l1_err, l0_err};
    assign sync_v    = {l1_sync, l0_sync};
    assign disp_v    = {l1_disperr, l0_disperr};
    assign pat_v     = {l1_patdet, l0_patdet};
    assign del_v     = {l1_rm_del, l0_rm_del};
    assign ins_v     = {l1_rm_ins, l0_rm_ins};
    assign rd_v      = {l1_rdisp, l0_rdisp};

    // One packer per lane; lane 1 is only used in the doubled modes
    // Both packers always run and the word mux picks lane 1 only when doubled,
    // which keeps the lane logic identical and the selection in one place
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
            lane_field_pack u_pack (
                .code    (code_v[gi]),
                .raw     (raw),
                .pipe    (pipe),
                .ctrl    (ctrl_v[gi]),
                .err     (err_v[gi]),
                .sync    (sync_v[gi]),
                .disperr (disp_v[gi]),
                .patdet  (pat_v[gi]),
                .rm_del  (del_v[gi]),
                .rm_ins  (ins_v[gi]),
                .pipe_st (pst_v[gi]),
                .rdisp   (rd_v[gi]),
                .field   (field_v[gi])
            );
        end
    endgenerate

    assign field0 = field_v[0];
    assign field1 = field_v[1];

    ////////////////////////////////////////////////////////////////////////
    // Word assembly

    // Word layout per 16-bit lane field, lane 1 sitting 16 bits higher:
    //   coded modes: 7:0 byte, 8 control character, 9 code violation
    //   raw modes:   9:0 undecoded code group
    //   all modes:   10 sync, 11 disparity error, 12 pattern detect
    //   non-PIPE:    13 rate-match deletion, 14 rate-match insertion
    //   PIPE:        14:13 receive status
    //   all modes:   15 running disparity
    // Single-lane modes leave 31:16 at zero; doubled modes fill both fields.
    // The word is registered so the fabric sees a clean value for a whole
    // cycle; the cost is one cycle of latency against the lane inputs.

    // Upper half is forced to zero in single-lane modes so it never floats
    always @* begin
        word_d = word_q;
        if (in_valid && enable) begin
            if (dbl) begin
                word_d = {field1, field0};
            end else begin
                word_d = {16'h0000, field0};
            end
        end
    end

    // Word and its strobe come from flip-flops; the word holds between strobes
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            word_q  <= `WORD_RST;
            valid_q <= 1'b0;
        end else begin
            word_q  <= word_d;
            valid_q <= in_valid && enable;
        end
    end

    assign rx_word       = word_q;
    assign rx_word_valid = valid_q;

    ////////////////////////////////////////////////////////////////////////
    // Sync status capture

    // Sync is a level; keep the last value seen with a word for software
    // Lane 1 sync is forced low by each word accepted in a single-lane mode; after a
    // change from a doubled mode the old lane 1 flag stands until such a word arrives
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync0_q <= 1'b0;
            sync1_q <= 1'b0;
        end else if (in_valid && enable) begin
            sync0_q <= l0_sync;
            sync1_q <= dbl ? l1_sync : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate-match event counters

    // In PIPE mode these bits carry status, so nothing is counted
    // Lane 1 events count only in the doubled modes, where that lane is live;
    // in single-lane modes its inputs may carry anything
    assign del_inc = (in_valid && enable && !pipe) ?
                     ({1'b0, l0_rm_del} + {1'b0, dbl & l1_rm_del}) : 2'h0;
    assign ins_inc = (in_valid && enable && !pipe) ?
                     ({1'b0, l0_rm_ins} + {1'b0, dbl & l1_rm_ins}) : 2'h0;

    // Any write to a counter clears it; events in that cycle still count
    assign del_clr = reg_wr && hit(reg_addr, `REG_DEL_CNT);
    assign ins_clr = reg_wr && hit(reg_addr, `REG_INS_CNT);

    event_counter #(
        .CNT_W (CNT_W)
    ) u_del_cnt (
        .mclk  (mclk),
        .rstn  (rstn),
        .inc   (del_inc),
        .clr   (del_clr),
        .count (del_cnt)
    );

    event_counter #(
        .CNT_W (CNT_W)
    ) u_ins_cnt (
        .mclk  (mclk),
        .rstn  (rstn),
        .inc   (ins_inc),
        .clr   (ins_clr),
        .count (ins_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    // Register map:
    //   0x00 control: enable, width mode, PIPE select (read and write)
    //   0x04 status: last valid, mode, PIPE, per-lane sync (read only)
    //   0x08 last packed word (read only)
    //   0x0C deletion count, 0x10 insertion count (any write clears)
    // A mode write acts on the next accepted word; a word already presented
    // keeps the layout it was packed with

    // Only the control register takes write data; counter writes only clear the counter
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= `CTRL_RST;
        end else if (reg_wr && hit(reg_addr, `REG_CTRL)) begin
            ctrl_q <= reg_wdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads

    // Unmapped addresses and reserved bits read as zero
    always @* begin
        rdata_d = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL: begin
                    rdata_d[3:0] = ctrl_q;
                end
                `REG_STATUS: begin
                    rdata_d[`STAT_VALID]                  = valid_q;
                    rdata_d[`STAT_WMODE_LO+1:`STAT_WMODE_LO] = wmode;
                    rdata_d[`STAT_PIPE]                   = pipe;
                    rdata_d[`STAT_SYNC0]                  = sync0_q;
                    rdata_d[`STAT_SYNC1]                  = sync1_q;
                end
                `REG_LAST: begin
                    rdata_d = word_q;
                end
                `REG_DEL_CNT: begin
                    rdata_d[CNT_W-1:0] = del_cnt;
                end
                `REG_INS_CNT: begin
                    rdata_d[CNT_W-1:0] = ins_cnt;
                end
                default: begin
                    rdata_d = 32'h00000000;
                end
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe, zero otherwise
    // The zero default lets several such ports be ORed onto one read bus
    // without a separate select in the fabric
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule // rx_fabric_word_packer

/* File: rx_packer_defs.vh */
// Constants for the receive fabric word packer
`ifndef RX_PACKER_DEFS_VH
`define RX_PACKER_DEFS_VH

// Fabric width modes
`define WMODE_8          2'h0
`define WMODE_10         2'h1
`define WMODE_16         2'h2
`define WMODE_20         2'h3

// Lane field width and bit positions inside one 16-bit lane field
`define LANE_W           16
`define FLD_BYTE_HI      7
`define FLD_CODE_HI      9
`define FLD_CTRL         8
`define FLD_ERR          9
`define FLD_SYNC         10
`define FLD_DISPERR      11
`define FLD_PATDET       12
`define FLD_RM_DEL       13
`define FLD_RM_INS       14
`define FLD_RDISP        15

// Register offsets (byte addresses)
`define REG_CTRL         5'h00
`define REG_STATUS       5'h04
`define REG_LAST         5'h08
`define REG_DEL_CNT      5'h0C
`define REG_INS_CNT      5'h10

// Control register fields
`define CTRL_EN          0
`define CTRL_WMODE_LO    1
`define CTRL_WMODE_HI    2
`define CTRL_PIPE        3

// Status register fields
`define STAT_VALID       0
`define STAT_WMODE_LO    1
`define STAT_PIPE        3
`define STAT_SYNC0       4
`define STAT_SYNC1       5

// Reset values
`define CTRL_RST         4'h1
`define WORD_RST         32'h00000000

`endif

/* File: lane_field_pack.v */
// One lane's 16-bit field of the receive word: data plus status flags
`timescale 1ns/1ps
`include "rx_packer_defs.vh"

module lane_field_pack (
    // Lane data and mode
    input  wire [9:0]            code,
    input  wire                  raw,
    input  wire                  pipe,
    // Lane status flags
    input  wire                  ctrl,
    input  wire                  err,
    input  wire                  sync,
    input  wire                  disperr,
    input  wire                  patdet,
    input  wire                  rm_del,
    input  wire                  rm_ins,
    input  wire [1:0]            pipe_st,
    input  wire                  rdisp,
    // Packed field
    output reg  [`LANE_W-1:0]    field
);

    // Raw mode overlays the code group on the control and error bits
    always @* begin
        field = {`LANE_W{1'b0}};
        if (raw) begin
            field[`FLD_CODE_HI:0] = code;
        end else begin
            field[`FLD_BYTE_HI:0] = code[`FLD_BYTE_HI:0];
            field[`FLD_CTRL]      = ctrl;
            field[`FLD_ERR]       = err;
        end
        field[`FLD_SYNC]    = sync;
        field[`FLD_DISPERR] = disperr;
        field[`FLD_PATDET]  = patdet;
        // Status pair is shared: rate-match flags or PIPE status
        if (pipe) begin
            field[`FLD_RM_INS:`FLD_RM_DEL] = pipe_st;
        end else begin
            field[`FLD_RM_DEL] = rm_del;
            field[`FLD_RM_INS] = rm_ins;
        end
        field[`FLD_RDISP] = rdisp;
    end

endmodule // lane_field_pack

/* File: event_counter.v */
// Saturating event counter with clear; a count in the clear cycle survives
`timescale 1ns/1ps

module event_counter #(
    parameter CNT_W = 16
) (
    // Clock and reset
    input  wire              mclk,
    input  wire              rstn,
    // Events and clear
    input  wire [1:0]        inc,
    input  wire              clr,
    // Count
    output wire [CNT_W-1:0]  count
);

    reg  [CNT_W-1:0] cnt_q;
    reg  [CNT_W-1:0] cnt_d;
    wire [CNT_W:0]   sum;

    // Clear drops the old count but keeps this cycle's events
    assign sum = {1'b0, (clr ? {CNT_W{1'b0}} : cnt_q)} + {{(CNT_W-1){1'b0}}, inc};

    // Saturate instead of wrapping so software never sees a small false count
    always @* begin
        cnt_d = sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0];
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= {CNT_W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;

endmodule // event_counter

/* File: packer_props.sv */
// Property checker for the receive fabric word packer
`timescale 1ns/1ps

module packer_props (
    // Clock and reset
    input wire        mclk,
    input wire        rstn,
    // Lane 0 inputs
    input wire [9:0]  l0_code,
    input wire        l0_ctrl,
    input wire        l0_err,
    input wire        l0_sync,
    input wire        l0_disperr,
    input wire        l0_patdet,
    input wire        l0_rm_del,
    input wire        l0_rm_ins,
    input wire [1:0]  l0_pipe_st,
    input wire        l0_rdisp,
    // Lane 1 inputs
    input wire [9:0]  l1_code,
    input wire        l1_ctrl,
    input wire        l1_err,
    // Word strobe and register port
    input wire        in_valid,
    input wire [4:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // Fabric side
    input wire [31:0] rx_word,
    input wire        rx_word_valid
);
    ////////////////////////////////////////////////////////////////
    // Mirror of the control register, since the mode is not visible at the ports
    logic [3:0] ctrl_q;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) ctrl_q <= 4'h1;
        else if (reg_wr && reg_addr == 5'h00) ctrl_q <= reg_wdata[3:0];
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Accepted word, split by coding
    sequence take_s; in_valid && ctrl_q[0]; endsequence
    sequence coded_s; take_s ##0 !ctrl_q[1]; endsequence
    sequence raw_s; take_s ##0 ctrl_q[1]; endsequence

    ////////////////////////////////////////////////////////////////
    word_valid_a: assert property (
        take_s |=> rx_word_valid
    ) else $error("accepted word not presented");
    refuse_word_a: assert property (
        !(in_valid && ctrl_q[0]) |=> !rx_word_valid
    ) else $error("valid without accepted word");
    hold_word_a: assert property (
        !rx_word_valid |-> $stable(rx_word)
    ) else $error("word changed without valid");
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == 32'h00000000
    ) else $error("read data outside read cycle");
    byte_lo_a: assert property (
        coded_s |=> rx_word[9:0] == $past({l0_err, l0_ctrl, l0_code[7:0]})
    ) else $error("lower coded byte misplaced");
    raw_lo_a: assert property (
        raw_s |=> rx_word[9:0] == $past(l0_code)
    ) else $error("lower raw code group misplaced");
    status_lo_a: assert property (
        take_s |=> rx_word[12:10] == $past({l0_patdet, l0_disperr, l0_sync}) && rx_word[15] == $past(l0_rdisp)
    ) else $error("lower status flags misplaced");
    rate_lo_a: assert property (
        take_s ##0 !ctrl_q[3] |=> rx_word[14:13] == $past({l0_rm_ins, l0_rm_del})
    ) else $error("rate-match flags misplaced");
    pipe_lo_a: assert property (
        take_s ##0 ctrl_q[3] |=> rx_word[14:13] == $past(l0_pipe_st)
    ) else $error("receive status misplaced");
    upper_zero_a: assert property (
        take_s ##0 !ctrl_q[2] |=> rx_word[31:16] == 16'h0000
    ) else $error("upper half not zero in single lane");
    byte_hi_a: assert property (
        coded_s ##0 ctrl_q[2] |=> rx_word[25:16] == $past({l1_err, l1_ctrl, l1_code[7:0]})
    ) else $error("upper coded byte misplaced");
    raw_hi_a: assert property (
        raw_s ##0 ctrl_q[2] |=> rx_word[25:16] == $past(l1_code)
    ) else $error("upper raw code group misplaced");
endmodule // packer_props

bind rx_fabric_word_packer packer_props u_packer_props (
    .mclk(mclk), .rstn(rstn), .l0_code(l0_code), .l0_ctrl(l0_ctrl), .l0_err(l0_err), .l0_sync(l0_sync),
    .l0_disperr(l0_disperr), .l0_patdet(l0_patdet), .l0_rm_del(l0_rm_del), .l0_rm_ins(l0_rm_ins),
    .l0_pipe_st(l0_pipe_st), .l0_rdisp(l0_rdisp), .l1_code(l1_code), .l1_ctrl(l1_ctrl), .l1_err(l1_err),
    .in_valid(in_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_word(rx_word), .rx_word_valid(rx_word_valid)
);

/* File: fabric_sink.sv */
// Fabric-side consumer that takes each presented receive word
`timescale 1ns/1ps

module fabric_sink (
    // Clock and reset
    input  wire        mclk,
    input  wire        rstn,
    // Receive word from the packer
    input  wire [31:0] rx_word,
    input  wire        rx_word_valid,
    // Capture results
    output reg  [7:0]  words_q,
    output reg  [31:0] last_q
);
    // The word path has no back-pressure, so every valid cycle must be taken here
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            words_q <= 8'h00;
            last_q  <= 32'h00000000;
        end else if (rx_word_valid) begin
            words_q <= words_q + 8'h01;
            last_q  <= rx_word;
        end
    end
endmodule // fabric_sink

/* File: rx_fabric_word_packer_tb.sv */
// Self-checking bench for the receive fabric word packer
`timescale 1ns/1ps

module rx_fabric_word_packer_tb;
    logic        mclk;
    logic        rstn;
    logic [19:0] s0;
    logic [19:0] s1;
    logic        in_valid;
    logic [4:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    wire  [31:0] reg_rdata;
    wire  [31:0] rx_word;
    wire         rx_word_valid;
    wire  [7:0]  words_q;
    wire  [31:0] last_q;
    int          n_fail;
    int          n_tests;
    int          cyc = 0;
    logic [75:0] rows [8];

    ////////////////////////////////////////////////////////////////
    // Lane vector: {pipe status, rdisp, ins, del, patdet, disperr, sync, err, ctrl, code}
    rx_fabric_word_packer u_rx_fabric_word_packer (
        .mclk(mclk), .rstn(rstn), .l0_code(s0[9:0]), .l0_ctrl(s0[10]), .l0_err(s0[11]), .l0_sync(s0[12]),
        .l0_disperr(s0[13]), .l0_patdet(s0[14]), .l0_rm_del(s0[15]), .l0_rm_ins(s0[16]), .l0_rdisp(s0[17]),
        .l0_pipe_st(s0[19:18]), .l1_code(s1[9:0]), .l1_ctrl(s1[10]), .l1_err(s1[11]), .l1_sync(s1[12]),
        .l1_disperr(s1[13]), .l1_patdet(s1[14]), .l1_rm_del(s1[15]), .l1_rm_ins(s1[16]), .l1_rdisp(s1[17]),
        .l1_pipe_st(s1[19:18]), .in_valid(in_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_word(rx_word), .rx_word_valid(rx_word_valid)
    );
    fabric_sink u_fabric_sink (
        .mclk(mclk), .rstn(rstn), .rx_word(rx_word), .rx_word_valid(rx_word_valid), .words_q(words_q), .last_q(last_q)
    );

    // Free-running 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Register write and read, one-cycle strobes
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk("reg_rdata", e, reg_rdata);
    endtask

    // One word strobe; the answer stands only in the next cycle
    task automatic send(input logic [19:0] a, input logic [19:0] b, input logic v, input logic [31:0] e);
        @(posedge mclk);
        in_valid <= 1'b1;
        s0       <= a;
        s1       <= b;
        @(posedge mclk);
        in_valid <= 1'b0;
        #1;
        chk("rx_word_valid", {31'h0, v}, {31'h0, rx_word_valid});
        chk("rx_word", e, rx_word);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well above the fewer than a hundred cycles the run needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            finish_test;
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        rstn      = 1'b0;
        s0        = 20'h00000;
        s1        = 20'h00000;
        in_valid  = 1'b0;
        reg_addr  = 5'h00;
        reg_wdata = 32'h00000000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        n_fail    = 0;
        n_tests   = 0;
        // Rows: control, lane 0, lane 1, expected word
        rows[0] = {4'h1, 20'h007A5, 20'hFFFFF, 32'h000001A5};
        rows[1] = {4'h1, 20'hFF800, 20'hFFFFF, 32'h0000FE00};
        rows[2] = {4'h9, 20'h58055, 20'hFFFFF, 32'h00002055};
        rows[3] = {4'h3, 20'h2AEC3, 20'hFFFFF, 32'h0000AAC3};
        rows[4] = {4'h5, 20'h007A5, 20'hFF800, 32'hFE0001A5};
        rows[5] = {4'hD, 20'h58055, 20'hA00FF, 32'hC0FF2055};
        rows[6] = {4'h7, 20'h2AEC3, 20'h007A5, 32'h03A5AAC3};
        rows[7] = {4'hF, 20'h58055, 20'hFF800, 32'hFC002055};
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        rd(5'h00, 32'h00000001);
        rd(5'h14, 32'h00000000);
        for (int i = 0; i < 8; i++) begin
            wr(5'h00, {28'h0, rows[i][75:72]});
            send(rows[i][71:52], rows[i][51:32], 1'b1, rows[i][31:0]);
        end
        // Rate-match events outside PIPE only, lane 1 only when doubled
        rd(5'h0C, 32'h00000004);
        rd(5'h10, 32'h00000002);
        wr(5'h0C, 32'h00000000);
        rd(5'h0C, 32'h00000000);
        // Disabled channel: word refused, previous word holds
        wr(5'h00, 32'h00000000);
        send(20'h00011, 20'h00000, 1'b0, 32'hFC002055);
        rd(5'h08, 32'hFC002055);
        // Status keeps lane 1 sync from the last accepted doubled word
        rd(5'h04, 32'h00000020);
        // Back-to-back words in 8-bit mode
        wr(5'h00, 32'h00000001);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            in_valid <= (i < 3);
            s0       <= 20'(i + 1);
            #1;
            if (i > 0) begin
                chk("b2b word", 32'(i), rx_word);
                chk("b2b valid", 32'h00000001, {31'h0, rx_word_valid});
            end
        end
        @(posedge mclk);
        #1;
        chk("sink words", 32'h0000000B, {24'h0, words_q});
        chk("sink last", 32'h00000003, last_q);
        // Clear and deletion event in one cycle: the event survives the clear
        @(posedge mclk);
        in_valid <= 1'b1;
        s0       <= 20'h08000;
        reg_wr   <= 1'b1;
        reg_addr <= 5'h0C;
        @(posedge mclk);
        in_valid <= 1'b0;
        reg_wr   <= 1'b0;
        rd(5'h0C, 32'h00000001);
        // Reset in mid-run restores the defaults
        wr(5'h00, 32'h00000005);
        @(posedge mclk);
        rstn <= 1'b0;
        #1;
        chk("reset word", 32'h00000000, rx_word);
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rd(5'h00, 32'h00000001);
        finish_test;
    end
endmodule // rx_fabric_word_packer_tb
